// ===== src/motor_pwm_map.vh
// Register map and field constants for the motor modulator configuration.
`ifndef MOTOR_PWM_MAP_VH
`define MOTOR_PWM_MAP_VH
`define CTL0_ADDR 12'hf20
`define CTL1_ADDR 12'hf21
`define DB_ADDR 12'hf22
`define PERIOD_ADDR 12'hf2a
`define DUTY0_ADDR 12'hf2b
`define DUTY1_ADDR 12'hf2c
`define DUTY2_ADDR 12'hf2d
`define CTL0_ENABLE 0
`define CTL0_READY 1
`define CTL1_RATE_HI 7
`define CTL1_RATE_LO 6
`define CTL1_INDEP 5
`define CTL1_POL_HI 4
`define CTL1_POL_LO 2
`define CTL1_DIV_HI 1
`define CTL1_DIV_LO 0
`define DB_RESET 8'h01
`define PERIOD_RESET 8'hff
`endif

// ===== src/pair_deadband.v
// One output pair: polarity, complementary or independent mode, dead band.
`timescale 1ns/1ps
`include "motor_pwm_map.vh"
module pair_deadband (
   input wire clk_in,
   input wire reset_in,
   input wire run_in,
   input wire tick_in,
   input wire compare_in,
   input wire indep_in,
   input wire invert_in,
   input wire [7:0] dead_in,
   output reg high_out,
   output reg low_out
);
   reg prev_q;
   reg [7:0] dead_q;
   reg high_d;
   reg low_d;
   // A change of the compare level starts a fresh dead-band count.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         prev_q <= 1'b0;
         dead_q <= 8'h00;
      end else if (!run_in) begin
         prev_q <= 1'b0;
         dead_q <= 8'h00;
      end else if (tick_in) begin
         prev_q <= compare_in;
         if (compare_in != prev_q)
            dead_q <= dead_in;
         else if (dead_q != 8'h00)
            dead_q <= dead_q - 8'h01;
      end
   end
   always @* begin
      high_d = 1'b0;
      low_d = 1'b0;
      if (indep_in) begin
         high_d = compare_in;
         low_d = compare_in;
      end else if (dead_q == 8'h00 && compare_in == prev_q) begin
         high_d = compare_in;
         low_d = !compare_in;
      end
   end
   // Inversion applies only while running so the off-state stays low.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         high_out <= 1'b0;
         low_out <= 1'b0;
      end else if (!run_in) begin
         high_out <= 1'b0;
         low_out <= 1'b0;
      end else begin
         high_out <= high_d ^ invert_in;
         low_out <= low_d ^ invert_in;
      end
   end
endmodule

// ===== src/motor_pwm_reload_deadband.v
// Modulator configuration, prescaler, period counter and reload control.
`timescale 1ns/1ps
`include "motor_pwm_map.vh"
module motor_pwm_reload_deadband (
   input wire clk_in,
   input wire reset_in,
   input wire external_modulator_clock_in,
   input wire clock_source_in,
   input wire [11:0] addr_in,
   input wire [7:0] wdata_in,
   input wire write_in,
   input wire read_in,
   output reg [7:0] rdata_out,
   output wire [5:0] pwm_out,
   output reg [5:0] pwm_oe_out,
   output reg reload_out
);
   reg [7:0] ctl0_q;
   reg [7:0] ctl1_q;
   reg [7:0] dead_band_time_q;
   reg [7:0] period_hold_q;
   reg [7:0] period_q;
   reg [23:0] duty_hold_q;
   reg [23:0] duty_q;
   reg [1:0] rate_q;
   reg [1:0] divide_q;
   reg [6:0] pre_q;
   reg [7:0] count_q;
   reg [2:0] periods_q;
   reg ext_prev_q;
   reg [7:0] rdata_d;
   wire run;
   wire src_edge;
   wire tick;
   wire period_end;
   wire reload;
   wire take_new;
   wire [1:0] new_rate;
   wire [1:0] new_divide;
   wire [2:0] compare;
   wire [5:0] pair_pins;

   function [6:0] div_mask;
      input [1:0] code;
      begin
         div_mask = (7'h01 << code) - 7'h01;
      end
   endfunction

   function [2:0] rate_mask;
      input [1:0] code;
      begin
         rate_mask = (3'h1 << code) - 3'h1;
      end
   endfunction

   assign run = ctl0_q[`CTL0_ENABLE];
   // The external clock is sampled; its rising edge forms the input tick.
   assign src_edge = clock_source_in ?
      (external_modulator_clock_in & ~ext_prev_q) : 1'b1;
   assign tick = run && src_edge && ((pre_q & div_mask(divide_q)) == 7'h00);
   assign period_end = tick && (count_q == period_q);
   // A reload falls on the period end that completes 2^rate periods.
   assign reload = period_end &&
      ((periods_q & rate_mask(rate_q)) == (3'h7 & rate_mask(rate_q)));
   // Period, duty and divide holding values are taken only when software has marked them ready.
   assign take_new = reload && ctl0_q[`CTL0_READY];
   // Holding copies of the buffered fields, as software last wrote them.
   assign new_rate = ctl1_q[`CTL1_RATE_HI:`CTL1_RATE_LO];
   assign new_divide = ctl1_q[`CTL1_DIV_HI:`CTL1_DIV_LO];

   ////////////////////////////////////////////////////////////////////////
   // Register writes.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ctl0_q <= 8'h00;
         ctl1_q <= 8'h00;
         dead_band_time_q <= `DB_RESET;
         period_hold_q <= `PERIOD_RESET;
         duty_hold_q <= 24'h000000;
      end else begin
         if (write_in) begin
            case (addr_in)
               `CTL0_ADDR: ctl0_q <= wdata_in;
               `CTL1_ADDR: ctl1_q <= wdata_in;
               `DB_ADDR: dead_band_time_q <= wdata_in;
               `PERIOD_ADDR: period_hold_q <= wdata_in;
               `DUTY0_ADDR: duty_hold_q[7:0] <= wdata_in;
               `DUTY1_ADDR: duty_hold_q[15:8] <= wdata_in;
               `DUTY2_ADDR: duty_hold_q[23:16] <= wdata_in;
               default: ;
            endcase
         end
         // Ready clears once consumed, unless software sets it again now.
         if (reload && ctl0_q[`CTL0_READY] &&
             !(write_in && addr_in == `CTL0_ADDR))
            ctl0_q[`CTL0_READY] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Working values and counters: prescaler first.
   // The reload edge counts as the first input edge of a new divide, so
   // the first tick after it is a full divided cycle away, never early.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pre_q <= 7'h00;
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= external_modulator_clock_in;
         if (!run)
            pre_q <= 7'h00;
         else if (take_new)
            pre_q <= 7'h01 & div_mask(new_divide);
         else if (src_edge)
            pre_q <= (pre_q + 7'h01) & div_mask(divide_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Period counter runs 0 up to the working period, one step per tick;
   // it holds at zero while stopped so every start begins a full period.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in)
         count_q <= 8'h00;
      else if (!run)
         count_q <= 8'h00;
      else if (tick)
         count_q <= period_end ? 8'h00 : count_q + 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////
   // Periods since the last reload; the rate is picked up at period end.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         periods_q <= 3'h0;
         rate_q <= 2'h0;
      end else if (!run) begin
         periods_q <= 3'h0;
         rate_q <= new_rate;
      end else if (period_end) begin
         periods_q <= reload ? 3'h0 : periods_q + 3'h1;
         rate_q <= new_rate;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Staged values move over only at a reload with values-ready set.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         divide_q <= 2'h0;
         period_q <= `PERIOD_RESET;
         duty_q <= 24'h000000;
      end else if (take_new) begin
         divide_q <= new_divide;
         period_q <= period_hold_q;
         duty_q <= duty_hold_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reload strobe and pin enables, registered for the pins.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         reload_out <= 1'b0;
         pwm_oe_out <= 6'h00;
      end else begin
         reload_out <= reload;
         pwm_oe_out <= {6{run}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port; divide and rate read from the holding copy.
   always @* begin
      case (addr_in)
         `CTL0_ADDR: rdata_d = ctl0_q;
         `CTL1_ADDR: rdata_d = ctl1_q;
         `DB_ADDR: rdata_d = dead_band_time_q;
         `PERIOD_ADDR: rdata_d = period_hold_q;
         `DUTY0_ADDR: rdata_d = duty_hold_q[7:0];
         `DUTY1_ADDR: rdata_d = duty_hold_q[15:8];
         `DUTY2_ADDR: rdata_d = duty_hold_q[23:16];
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in)
         rdata_out <= 8'h00;
      else if (read_in)
         rdata_out <= rdata_d;
      else
         rdata_out <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pairs, high side on the even pin.
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : pair
         // Compare is high while the count is below the pair's duty.
         assign compare[g] = count_q < duty_q[g*8 +: 8];
         pair_deadband i_pair_deadband (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .run_in(run),
            .tick_in(tick),
            .compare_in(compare[g]),
            .indep_in(ctl1_q[`CTL1_INDEP]),
            .invert_in(ctl1_q[`CTL1_POL_LO + g]),
            .dead_in(dead_band_time_q),
            .high_out(pair_pins[2*g]),
            .low_out(pair_pins[2*g + 1])
         );
      end
   endgenerate
   assign pwm_out = pair_pins;
endmodule

// ===== verif/pwm_checker_sva.sv
// Port assertions for the modulator configuration block.
`timescale 1ns/1ps
`include "motor_pwm_map.vh"
module pwm_checker (
   input wire clk_in,
   input wire reset_in,
   input wire [11:0] addr_in,
   input wire [7:0] wdata_in,
   input wire write_in,
   input wire read_in,
   input wire [7:0] rdata_out,
   input wire [5:0] pwm_out,
   input wire [5:0] pwm_oe_out,
   input wire reload_out
);
   reg en_q;
   reg [7:0] c1_q;
   reg [7:0] db_q;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   // Shadow of what software wrote, so outputs can be tied to settings.
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         en_q <= 1'b0;
         c1_q <= 8'h00;
         db_q <= `DB_RESET;
      end else if (write_in) begin
         if (addr_in == `CTL0_ADDR) en_q <= wdata_in[`CTL0_ENABLE];
         if (addr_in == `CTL1_ADDR) c1_q <= wdata_in;
         if (addr_in == `DB_ADDR) db_q <= wdata_in;
      end
   end
   property apart(int k);
      en_q [*3] ##0 !c1_q[5] ##0 !$past(c1_q[5]) |->
         !((pwm_out[2*k] ^ $past(c1_q[2+k])) &&
           (pwm_out[2*k+1] ^ $past(c1_q[2+k])));
   endproperty
   rd_idle_a: assert property (!read_in |=> rdata_out == 8'h00)
      else $error("read data not idle");
   ctl1_read_a: assert property (read_in && addr_in == `CTL1_ADDR |=>
      rdata_out == c1_q) else $error("control one readback wrong");
   oe_track_a: assert property (pwm_oe_out == {6{$past(en_q)}})
      else $error("output enables wrong");
   out_off_a: assert property (!en_q [*2] |=> pwm_out == 6'h00)
      else $error("outputs not off while disabled");
   no_reload_a: assert property (!en_q [*3] |-> !reload_out)
      else $error("reload while stopped");
   pair_zero_a: assert property (apart(0))
      else $error("pair zero overlap");
   pair_one_a: assert property (apart(1))
      else $error("pair one overlap");
   pair_two_a: assert property (apart(2))
      else $error("pair two overlap");
   dead_gap_a: assert property (en_q && c1_q[5:0] == 6'h00 &&
      db_q == 8'h01 && $fell(pwm_out[0]) |-> !pwm_out[1] [*2])
      else $error("dead band too short");
   cover property (reload_out);
   cover property (en_q && $rose(pwm_out[1]));
   cover property (read_in && addr_in == `CTL1_ADDR);
endmodule
bind motor_pwm_reload_deadband pwm_checker i_pwm_checker (
   .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
   .rdata_out(rdata_out), .pwm_out(pwm_out), .pwm_oe_out(pwm_oe_out),
   .reload_out(reload_out)
);

// ===== verif/gate_driver_model.sv
// Gate driver stand-in that counts shoot-through on complementary pairs.
`timescale 1ns/1ps
module gate_driver_model (
   input wire clk_in,
   input wire [5:0] pwm_in,
   input wire [5:0] oe_in,
   output integer shoot_count
);
   integer k;
   initial shoot_count = 0;
   always @(posedge clk_in) begin
      for (k = 0; k < 3; k = k + 1) begin
         if (oe_in[2*k] && pwm_in[2*k] && pwm_in[2*k+1]) begin
            shoot_count = shoot_count + 1;
         end
      end
   end
endmodule

// ===== verif/motor_pwm_reload_deadband_tb.sv
// Self-checking bench for the modulator configuration block.
`timescale 1ns/1ps
`include "motor_pwm_map.vh"
module motor_pwm_reload_deadband_tb;
   logic clk_in = 0;
   logic reset_in = 1;
   logic write_in = 0;
   logic read_in = 0;
   logic [11:0] addr_in = 0;
   logic [7:0] wdata_in = 0;
   logic [7:0] rdata_out;
   logic [7:0] rd_v;
   logic [5:0] pwm_out;
   logic [5:0] pwm_oe_out;
   logic reload_out;
   integer n_fail = 0;
   integer check_count = 0;
   integer shoot;
   integer i;
   integer gap;
   integer hi0;
   integer hi1;
   logic ext_clk = 0;
   logic ext_sel = 0;
   // Rows: control one, then pin 0 and pin 1 high cycles in one period.
   logic [23:0] pats [0:2] = '{{8'h00, 8'h01, 8'h03},
      {8'h20, 8'h03, 8'h03}, {8'h04, 8'h07, 8'h05}};
   // Rows: address, data written, value read back.
   logic [27:0] rows [0:4] = '{{`DB_ADDR, 8'h05, 8'h05},
      {`DB_ADDR, 8'h01, 8'h01}, {`CTL1_ADDR, 8'h3c, 8'h3c},
      {`CTL1_ADDR, 8'h00, 8'h00}, {12'h000, 8'h55, 8'h00}};
   motor_pwm_reload_deadband i_motor_pwm_reload_deadband (
      .clk_in(clk_in), .reset_in(reset_in),
      .external_modulator_clock_in(ext_clk), .clock_source_in(ext_sel),
      .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
      .read_in(read_in), .rdata_out(rdata_out), .pwm_out(pwm_out),
      .pwm_oe_out(pwm_oe_out), .reload_out(reload_out));
   gate_driver_model i_gate_driver_model (.clk_in(clk_in),
      .pwm_in(pwm_out), .oe_in(pwm_oe_out), .shoot_count(shoot));
   initial begin
      forever #25 clk_in = ~clk_in;
   end
   // External input clock: one rising edge every two system clocks.
   always @(posedge clk_in) ext_clk <= ~ext_clk;
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      write_in <= 1'b1;
      @(posedge clk_in);
      write_in <= 1'b0;
   endtask
   task rd(input logic [11:0] a);
      @(posedge clk_in);
      addr_in <= a;
      read_in <= 1'b1;
      @(posedge clk_in);
      read_in <= 1'b0;
      @(negedge clk_in);
      rd_v = rdata_out;
   endtask
   task complete_run;
      $display("checks %0d errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Waits for n reload pulses; cycles up to the last of them since the one before land in gap.
   task wait_rl(input integer n);
      repeat (n) begin
         gap = 1;
         @(negedge clk_in);
         while (reload_out !== 1'b1) begin
            @(negedge clk_in);
            gap = gap + 1;
            if (gap > 3000) begin
               $display("ERROR %0t no reload pulse", $time);
               n_fail = n_fail + 1;
               complete_run;
            end
         end
      end
   endtask
   // High cycles of pins 0 and 1 over n cycles land in hi0 and hi1.
   task count_hi(input integer n);
      hi0 = 0;
      hi1 = 0;
      repeat (n) begin
         @(negedge clk_in);
         hi0 = hi0 + pwm_out[0];
         hi1 = hi1 + pwm_out[1];
      end
   endtask
   initial begin
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      rd(`DB_ADDR);
      chk(rd_v, `DB_RESET);
      rd(`CTL1_ADDR);
      chk(rd_v, 8'h00);
      for (i = 0; i < 5; i = i + 1) begin
         wr(rows[i][27:16], rows[i][15:8]);
         rd(rows[i][27:16]);
         chk(rd_v, rows[i][7:0]);
      end
      wr(`PERIOD_ADDR, 8'h07);
      wr(`DUTY0_ADDR, 8'h03);
      wr(`CTL0_ADDR, 8'h03);
      for (i = 0; i < 4; i = i + 1) begin
         wr(`CTL1_ADDR, {i[1:0], 6'h00});
         wait_rl(3);
         chk(gap[7:0], 8'h08 << i);
      end
      wr(`CTL1_ADDR, 8'h01);
      wait_rl(3);
      chk(gap[7:0], 8'h08);
      wr(`CTL0_ADDR, 8'h03);
      wait_rl(2);
      chk(gap[7:0], 8'h10);
      wait_rl(1);
      chk(gap[7:0], 8'h10);
      chk({2'b00, pwm_oe_out}, 8'h3f);
      wr(`CTL0_ADDR, 8'h00);
      repeat (3) @(negedge clk_in);
      chk({2'b00, pwm_out}, 8'h00);
      chk({2'b00, pwm_oe_out}, 8'h00);
      chk({7'h00, shoot != 0}, 8'h00);
      // External input clock with divide by one gives 16-cycle periods.
      wr(`CTL1_ADDR, 8'h00);
      ext_sel <= 1'b1;
      wr(`CTL0_ADDR, 8'h03);
      wait_rl(3);
      chk(gap[7:0], 8'h10);
      wr(`CTL0_ADDR, 8'h00);
      ext_sel <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
         wr(`CTL1_ADDR, pats[i][23:16]);
         wr(`CTL0_ADDR, 8'h01);
         wait_rl(1);
         count_hi(8);
         chk(hi0[7:0], pats[i][15:8]);
         chk(hi1[7:0], pats[i][7:0]);
         wr(`CTL0_ADDR, 8'h00);
      end
      // Reset in mid-run puts back the reset values and stops the pins.
      wr(`DB_ADDR, 8'h05);
      wr(`CTL0_ADDR, 8'h01);
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      chk({2'b00, pwm_out}, 8'h00);
      chk({2'b00, pwm_oe_out}, 8'h00);
      rd(`DB_ADDR);
      chk(rd_v, `DB_RESET);
      complete_run;
   end
endmodule
